// *** flash_pkg.sv ***
package flash_pkg;

  localparam int CLOCK_MHZ = 20;
  // Suspend latencies in microseconds, and the same in clock cycles.
  localparam int PROGRAM_SUSPEND_LATENCY_US = 30;
  localparam int ERASE_SUSPEND_LATENCY_US = 30;
  localparam int PROGRAM_SUSPEND_LATENCY_CYC = PROGRAM_SUSPEND_LATENCY_US * CLOCK_MHZ;
  localparam int ERASE_SUSPEND_LATENCY_CYC = ERASE_SUSPEND_LATENCY_US * CLOCK_MHZ;
  localparam int LATENCY_W = 12;

  localparam int ADDR_W = 24;
  localparam int TOP_ADDRESS_BIT = 18;
  localparam int PAGE_SHIFT = 8;
  localparam int SECTOR_SHIFT = 12;
  localparam int BLOCK32_SHIFT = 15;
  localparam int BLOCK64_SHIFT = 16;
  localparam int SECTOR_COUNT = 128;

  localparam int WIP_BIT = 0;
  localparam int WEL_BIT = 1;
  localparam int SUS_BIT = 15;
  localparam logic [15:0] STATUS_RESET = 16'h0000;
  localparam logic LOCK_RESET = 1'b1;
  localparam logic [2:0] ADDR_FRAME_BYTES = 3'h4;

  localparam logic [7:0] WRITE_ENABLE_CMD = 8'h06;
  localparam logic [7:0] WRITE_DISABLE_CMD = 8'h04;
  localparam logic [7:0] STATUS_READ_CMD = 8'h05;
  localparam logic [7:0] STATUS_READ_HIGH_CMD = 8'h35;
  localparam logic [7:0] SIGNATURE_READ_CMD = 8'hAB;
  localparam logic [7:0] RESET_ARM_CMD = 8'h66;
  localparam logic [7:0] RESET_FIRE_CMD = 8'h99;
  localparam logic [7:0] IDLE_CMD = 8'h00;
  localparam logic [7:0] RESUME_CMD = 8'h7A;
  localparam logic [7:0] PAGE_WRITE_CMD = 8'h02;
  localparam logic [7:0] QUAD_PAGE_WRITE_CMD = 8'h32;
  localparam logic [7:0] SINGLE_LOCK_CMD = 8'h36;
  localparam logic [7:0] SINGLE_UNLOCK_CMD = 8'h39;
  // Any code unused elsewhere in the command set will do here.
  localparam logic [7:0] SUSPEND_CMD = 8'hB0;

  // Accepted at any time after a suspend command.
  localparam logic [7:0] ANYTIME_OPS [7] = '{WRITE_DISABLE_CMD, STATUS_READ_CMD,
    STATUS_READ_HIGH_CMD, SIGNATURE_READ_CMD, RESET_ARM_CMD, RESET_FIRE_CMD, IDLE_CMD};
  // Accepted in either suspend type once the latency has passed.
  localparam logic [7:0] SUSPEND_OPS [21] = '{8'h03, 8'h0B, 8'h3B, 8'h6B, 8'hBB, 8'hEB,
    8'hE7, 8'h0C, 8'h38, 8'hFF, 8'h5A, 8'h9F, 8'h90, 8'h92, 8'h94, 8'h77, 8'hC0,
    RESUME_CMD, 8'h48, 8'h9B, 8'h3D};
  // Accepted during erase suspend only.
  localparam logic [7:0] ERASE_SUSPEND_OPS [10] = '{WRITE_ENABLE_CMD, PAGE_WRITE_CMD,
    QUAD_PAGE_WRITE_CMD, 8'h42, 8'h9E, 8'h9A, 8'h9C, 8'h9D, SINGLE_UNLOCK_CMD, 8'h98};

  typedef enum logic [2:0] {
    KIND_PAGE_PROG, KIND_PAGE_ERASE, KIND_SECTOR_ERASE, KIND_BLOCK32_ERASE, KIND_BLOCK64_ERASE
  } op_kind_e;

  typedef struct packed {
    logic tag;
    logic [7:0] opcode;
    logic [ADDR_W-1:0] addr;
    logic [2:0] bytes;
    logic aligned;
  } frame_s;

  typedef struct packed {
    logic op_start;
    op_kind_e kind;
    logic [ADDR_W-1:0] addr;
    logic done;
  } engine_s;

  typedef struct packed {
    logic go;
    logic [ADDR_W-1:0] addr;
  } program_req_s;

endpackage : flash_pkg

// *** link_receiver.sv ***
module link_receiver
  import flash_pkg::*;
(
  // Link pins
  input wire logic link_clock,
  input wire logic reset_n,
  input wire logic cs_n,
  input wire logic [3:0] serial_lines,
  // Frame handed to the system clock domain
  output frame_s frame
);

  logic fresh;
  logic serial_in;
  logic [7:0] shift;
  logic [2:0] bit_index;

  // Only the lowest line carries commands here; the other lines are never read.
  assign serial_in = serial_lines[0];

  // The link clock stops between frames, so the frame start is marked by chip select itself.
  always_ff @(posedge link_clock or posedge cs_n) begin
    if (cs_n) begin
      fresh <= 1'b1;
    end else begin
      fresh <= 1'b0;
    end
  end

  // These fields stand still while chip select is high, which is when the other domain reads them.
  always_ff @(posedge link_clock or negedge reset_n) begin
    if (!reset_n) begin
      frame <= '0;
      shift <= 8'h00;
      bit_index <= 3'h0;
    end else if (fresh) begin
      frame.tag <= ~frame.tag;
      frame.bytes <= 3'h0;
      frame.aligned <= 1'b0;
      shift <= {7'h00, serial_in};
      bit_index <= 3'h1;
    end else begin
      shift <= {shift[6:0], serial_in};
      bit_index <= bit_index + 3'h1;
      frame.aligned <= (bit_index == 3'h7);
      if (bit_index == 3'h7 && frame.bytes != 3'h7) begin
        frame.bytes <= frame.bytes + 3'h1;
      end
      if (bit_index == 3'h7 && frame.bytes == 3'h0) begin
        frame.opcode <= {shift[6:0], serial_in};
      end
      if (frame.bytes >= 3'h1 && frame.bytes <= 3'h3) begin
        frame.addr <= {frame.addr[ADDR_W-2:0], serial_in};
      end
    end
  end

endmodule : link_receiver

// *** flash_suspend_resume_lock.sv ***
module flash_suspend_resume_lock
  import flash_pkg::*;
#(
  parameter int PROGRAM_LATENCY = PROGRAM_SUSPEND_LATENCY_CYC,
  parameter int ERASE_LATENCY = ERASE_SUSPEND_LATENCY_CYC
) (
  // Clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // Serial link
  input wire logic link_clock,
  input wire logic cs_n,
  input wire logic [3:0] serial_lines,
  // Array engine
  input wire engine_s engine,
  output program_req_s nested_program,
  output logic array_halt,
  output logic op_abort,
  // Read guard
  input wire logic [ADDR_W-1:0] read_addr,
  output logic read_blocked,
  // Protection setup
  input wire logic protect_scheme_select,
  input wire logic protect_complement,
  input wire logic [4:0] protect_range_bits,
  // Status
  output logic [15:0] status_word
);

  typedef enum logic [2:0] {st_idle, st_busy, st_suspending, st_suspended, st_nested} state_e;

  state_e state;
  state_e next_state;
  frame_s frame;
  op_kind_e kind;
  logic [ADDR_W-1:0] op_addr;
  logic cs_meta, cs_sync, cs_prev, seen_tag;
  logic write_enable_latch, suspended_flag, reset_armed;
  logic next_wel, next_sus, next_armed;
  logic [15:0] next_status;
  logic [LATENCY_W-1:0] latency_count;
  logic [SECTOR_COUNT-1:0] lock_bits, next_lock, lock_sel;
  logic [7:0] opcode;
  logic frame_end, cmd_valid, allowed, accepted, erase_kind, latency_done;
  logic suspend_go, resume_go, nested_go, lock_frame, lock_go, unlock_go, fire;
  logic write_enable_cmd, write_disable_cmd, page_write, target_protected, in_target_region;

  link_receiver link_receiver_i (
    .link_clock(link_clock),
    .reset_n(reset_n),
    .cs_n(cs_n),
    .serial_lines(serial_lines),
    .frame(frame)
  );

  function automatic logic in_region(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] base,
                                     input op_kind_e k);
    logic [ADDR_W-1:0] mask;
    unique case (k)
      KIND_PAGE_PROG, KIND_PAGE_ERASE: mask = {ADDR_W{1'b1}} << PAGE_SHIFT;
      KIND_SECTOR_ERASE: mask = {ADDR_W{1'b1}} << SECTOR_SHIFT;
      KIND_BLOCK32_ERASE: mask = {ADDR_W{1'b1}} << BLOCK32_SHIFT;
      default: mask = {ADDR_W{1'b1}} << BLOCK64_SHIFT;
    endcase
    return ((a ^ base) & mask) == '0;
  endfunction : in_region

  // A simple top or bottom range of 64KB blocks; the widest range bit is not decoded.
  function automatic logic range_hit(input logic [ADDR_W-1:0] a, input logic [4:0] bp,
                                     input logic cmp);
    logic [3:0] span;
    logic [3:0] blk;
    logic hit;
    unique case (bp[2:0])
      3'h0: span = 4'h0;
      3'h1: span = 4'h1;
      3'h2: span = 4'h2;
      3'h3: span = 4'h4;
      default: span = 4'h8;
    endcase
    blk = {1'b0, a[TOP_ADDRESS_BIT:BLOCK64_SHIFT]};
    hit = bp[3] ? (blk < span) : (blk + span >= 4'h8);
    return hit ^ cmp;
  endfunction : range_hit

  // The outer blocks lock by 4KB sector, the inner ones by whole 64KB block.
  function automatic logic lock_hit(input logic [6:0] s, input logic [ADDR_W-1:0] a);
    logic [2:0] blk;
    blk = a[TOP_ADDRESS_BIT:BLOCK64_SHIFT];
    if (blk == 3'h0 || blk == 3'h7) begin
      return s == a[TOP_ADDRESS_BIT:SECTOR_SHIFT];
    end
    return s[6:4] == blk;
  endfunction : lock_hit

  // The frame fields are only read after chip select is seen high, when the link has gone quiet.
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      cs_meta <= 1'b1;
      cs_sync <= 1'b1;
      cs_prev <= 1'b1;
      seen_tag <= 1'b0;
    end else begin
      cs_meta <= cs_n;
      cs_sync <= cs_meta;
      cs_prev <= cs_sync;
      if (frame_end) begin
        seen_tag <= frame.tag;
      end
    end
  end

  assign frame_end = cs_sync & ~cs_prev;
  assign cmd_valid = frame_end & (frame.tag != seen_tag);
  assign opcode = frame.opcode;
  assign erase_kind = (kind != KIND_PAGE_PROG);

  // While suspending only the anytime list passes; after the latency the type lists join it.
  assign allowed = (state == st_idle) | (state == st_busy) | (opcode inside {ANYTIME_OPS})
    | ((state == st_suspended) & (opcode inside {SUSPEND_OPS}))
    | ((state == st_suspended) & erase_kind & (opcode inside {ERASE_SUSPEND_OPS}));
  assign accepted = cmd_valid & allowed;

  assign write_enable_cmd = accepted & (opcode == WRITE_ENABLE_CMD);
  assign write_disable_cmd = accepted & (opcode == WRITE_DISABLE_CMD);
  assign fire = accepted & (opcode == RESET_FIRE_CMD) & reset_armed;
  assign page_write = accepted & ((opcode == PAGE_WRITE_CMD) | (opcode == QUAD_PAGE_WRITE_CMD));

  assign suspend_go = cmd_valid & (opcode == SUSPEND_CMD) & (state == st_busy);
  assign resume_go = accepted & (opcode == RESUME_CMD) & (state == st_suspended);

  assign target_protected = protect_scheme_select ? lock_bits[frame.addr[TOP_ADDRESS_BIT:SECTOR_SHIFT]]
    : range_hit(frame.addr, protect_range_bits, protect_complement);
  assign in_target_region = in_region(frame.addr, op_addr, kind);
  assign nested_go = page_write & (state == st_suspended) & erase_kind & write_enable_latch & frame.aligned
    & (frame.bytes >= ADDR_FRAME_BYTES) & ~target_protected & ~in_target_region;

  assign lock_frame = frame.aligned & (frame.bytes == ADDR_FRAME_BYTES) & write_enable_latch;
  assign lock_go = accepted & (opcode == SINGLE_LOCK_CMD) & (state == st_idle) & lock_frame;
  assign unlock_go = accepted & (opcode == SINGLE_UNLOCK_CMD) & lock_frame
    & ((state == st_idle) | (state == st_suspended));

  assign latency_done = (state == st_suspending) & (latency_count == '0);

  always_comb begin
    next_state = state;
    if (fire) begin
      next_state = st_idle;
    end else begin
      unique case (state)
        st_idle: if (engine.op_start) next_state = st_busy;
        st_busy: begin
          if (engine.done) begin
            next_state = st_idle;
          end else if (suspend_go) begin
            next_state = st_suspending;
          end
        end
        st_suspending: begin
          if (engine.done) begin
            next_state = st_idle;
          end else if (latency_done) begin
            next_state = st_suspended;
          end
        end
        st_suspended: begin
          if (resume_go) begin
            next_state = st_busy;
          end else if (nested_go) begin
            next_state = st_nested;
          end
        end
        st_nested: if (engine.done) next_state = st_suspended;
      endcase
    end
  end

  always_comb begin
    next_wel = write_enable_latch;
    if (fire) begin
      next_wel = 1'b0;
    end else if (resume_go | nested_go) begin
      next_wel = 1'b1;
    end else if (latency_done) begin
      next_wel = 1'b0;
    end else if (state == st_nested) begin
      next_wel = ~engine.done;
    end else if (((state == st_busy) | (state == st_suspending)) & engine.done) begin
      next_wel = 1'b0;
    end else if (lock_go | unlock_go | write_disable_cmd) begin
      next_wel = 1'b0;
    end else if (write_enable_cmd) begin
      next_wel = 1'b1;
    end
  end

  always_comb begin
    next_sus = suspended_flag;
    if (fire | resume_go) begin
      next_sus = 1'b0;
    end else if (latency_done & ~engine.done) begin
      next_sus = 1'b1;
    end
  end

  // Any other accepted command disarms a pending reset, the idle command included.
  always_comb begin
    next_armed = reset_armed;
    if (accepted) begin
      next_armed = (opcode == RESET_ARM_CMD);
    end
  end

  always_comb begin
    next_status = STATUS_RESET;
    next_status[SUS_BIT] = next_sus;
    next_status[WEL_BIT] = next_wel;
    next_status[WIP_BIT] = next_state inside {st_busy, st_suspending, st_nested};
  end

  for (genvar s = 0; s < SECTOR_COUNT; s++) begin : g_lock
    assign lock_sel[s] = lock_hit(7'(s), frame.addr);
    assign next_lock[s] = fire ? LOCK_RESET
      : (lock_sel[s] & lock_go) ? 1'b1 : (lock_sel[s] & unlock_go) ? 1'b0 : lock_bits[s];
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      state <= st_idle;
      write_enable_latch <= 1'b0;
      suspended_flag <= 1'b0;
      reset_armed <= 1'b0;
      status_word <= STATUS_RESET;
      lock_bits <= {SECTOR_COUNT{LOCK_RESET}};
    end else begin
      state <= next_state;
      write_enable_latch <= next_wel;
      suspended_flag <= next_sus;
      reset_armed <= next_armed;
      status_word <= next_status;
      lock_bits <= next_lock;
    end
  end

  // The latency runs in the system clock so that a stopped link clock cannot stall it.
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      latency_count <= '0;
    end else if (suspend_go) begin
      latency_count <= erase_kind ? LATENCY_W'(ERASE_LATENCY - 1) : LATENCY_W'(PROGRAM_LATENCY - 1);
    end else if (latency_count != '0) begin
      latency_count <= latency_count - 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      kind <= KIND_PAGE_PROG;
      op_addr <= '0;
    end else if (state == st_idle && engine.op_start) begin
      kind <= engine.kind;
      op_addr <= engine.addr;
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      array_halt <= 1'b0;
      op_abort <= 1'b0;
      read_blocked <= 1'b0;
      nested_program <= '0;
    end else begin
      array_halt <= next_state inside {st_suspending, st_suspended, st_nested};
      op_abort <= fire;
      read_blocked <= (state inside {st_suspended, st_nested}) & in_region(read_addr, op_addr, kind);
      nested_program.go <= nested_go;
      if (nested_go) begin
        nested_program.addr <= frame.addr;
      end
    end
  end

  logic [LATENCY_W-1:0] hold_cycles;
  always_ff @(posedge clock) begin
    if (!reset_n || state != st_suspending) begin
      hold_cycles <= '0;
    end else begin
      hold_cycles <= hold_cycles + 1'b1;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  a_suspend_latency: assert property ((latency_done && !engine.done && !fire)
    |-> hold_cycles == LATENCY_W'((erase_kind ? ERASE_LATENCY : PROGRAM_LATENCY) - 1))
    else $error("suspend latency length wrong");
  a_suspend_bits: assert property ((state == st_suspending && next_state == st_suspended)
    |=> !status_word[WEL_BIT] && status_word[SUS_BIT] && state == st_suspended)
    else $error("suspend did not clear enable and set flag");
  a_flag_meaning: assert property (status_word[SUS_BIT] == (state inside {st_suspended, st_nested}))
    else $error("suspended flag disagrees with state");
  a_resume_bits: assert property (resume_go && !fire
    |=> status_word[WEL_BIT] && status_word[WIP_BIT] && !status_word[SUS_BIT] && state == st_busy)
    else $error("resume did not set status bits");
  a_nested_hold: assert property (state == st_nested |-> status_word[WEL_BIT] && status_word[WIP_BIT])
    else $error("nested write lost enable or busy");
  a_nested_no_suspend: assert property (state == st_nested |=> state != st_suspending)
    else $error("nested write was suspended");
  a_refused_cmd: assert property ((state == st_suspended && cmd_valid && !allowed && !engine.done)
    |=> $stable(status_word) && state == st_suspended)
    else $error("refused command changed state");
  a_idle_disarm: assert property ((accepted && opcode == IDLE_CMD) |=> !reset_armed)
    else $error("idle command left reset armed");
  a_reset_locks: assert property (fire |=> (&lock_bits) && state == st_idle && op_abort)
    else $error("reset did not relock array");
  a_lock_boundary: assert property ((cmd_valid && opcode == SINGLE_LOCK_CMD && !frame.aligned)
    |=> $stable(lock_bits))
    else $error("unaligned lock changed lock bits");
  a_idle_suspend: assert property ((state == st_idle && cmd_valid && opcode == SUSPEND_CMD)
    |=> !suspended_flag && state != st_suspending)
    else $error("suspend taken with nothing running");
  a_nested_region: assert property (nested_go |=> nested_program.go
    && !in_region(nested_program.addr, op_addr, kind))
    else $error("nested write inside suspended region");

  c_suspended: cover property (state == st_suspending ##1 state == st_suspended);
  c_nested: cover property (state == st_nested ##1 state == st_suspended);
  c_resume: cover property (resume_go);
  c_lock: cover property (lock_go);

endmodule : flash_suspend_resume_lock

// *** flash_host_model.sv ***
module flash_host_model (
  // Link pins
  output logic link_clock,
  output logic cs_n,
  output logic [3:0] serial_lines
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    link_clock = 1'b0;
    cs_n = 1'b0;
    serial_lines = 4'h5;
    // A rising chip select at start presets the device's frame-start flag before the first frame.
    #1 cs_n = 1'b1;
  end

  // The link clock only runs inside a frame; the upper lines carry noise the device must ignore.
  task automatic send(input logic [7:0] op, input logic [23:0] addr, input int nbits, input logic [2:0] noise);
    logic [31:0] word;
    word = {op, addr};
    #3;
    cs_n = 1'b0;
    for (int i = 0; i < nbits; i++) begin
      serial_lines = {noise ^ 3'(i), word[31 - i]};
      #7.5 link_clock = 1'b1;
      #7.5 link_clock = 1'b0;
    end
    cs_n = 1'b1;
    // A released line must not keep showing its last value.
    serial_lines = ~serial_lines;
  endtask : send
endmodule : flash_host_model

// *** flash_suspend_resume_lock_tb_top.sv ***
module flash_suspend_resume_lock_tb_top import flash_pkg::*; ;
  timeunit 1ns;
  timeprecision 100ps;
  // A short latency keeps the run brief; every expectation follows from it.
  localparam int LAT = 8;
  // The device does not police the resume hold, so the bench keeps it itself.
  localparam int RESUME_HOLD = 20;
  logic clock, reset_n, link_clock, cs_n;
  logic [3:0] serial_lines;
  engine_s engine;
  program_req_s nested_program;
  logic array_halt, op_abort, read_blocked, protect_scheme_select, protect_complement;
  logic [ADDR_W-1:0] read_addr;
  logic [4:0] protect_range_bits;
  logic [15:0] status_word;
  logic [31:0] lfsr_state = 32'h5707;
  int num_errors = 0;
  int check_count = 0;
  int abort_due = 0;
  logic [15:0] st_q[$];
  logic [23:0] go_q[$];
  logic [15:0] prev_status = 16'h0000;

  flash_suspend_resume_lock #(.PROGRAM_LATENCY(LAT), .ERASE_LATENCY(LAT)) flash_suspend_resume_lock_i (
    .clock(clock), .reset_n(reset_n), .link_clock(link_clock), .cs_n(cs_n), .serial_lines(serial_lines),
    .engine(engine), .nested_program(nested_program), .array_halt(array_halt), .op_abort(op_abort),
    .read_addr(read_addr), .read_blocked(read_blocked), .protect_scheme_select(protect_scheme_select),
    .protect_complement(protect_complement), .protect_range_bits(protect_range_bits), .status_word(status_word));
  flash_host_model flash_host_model_i (.link_clock(link_clock), .cs_n(cs_n), .serial_lines(serial_lines));

  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next

  task automatic tally(input logic [23:0] got, input logic [23:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : tally

  task automatic chk_status(input logic [15:0] got, input logic [15:0] exp);
    tally({8'h00, got}, {8'h00, exp});
  endtask : chk_status

  task automatic chk_addr(input logic [23:0] got, input logic [23:0] exp);
    tally(got, exp);
  endtask : chk_addr

  task automatic chk_level(input logic got, input logic exp);
    tally({23'h000000, got}, {23'h000000, exp});
  endtask : chk_level

  task automatic test_done();
    $display("checks=%0d errors=%0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : test_done

  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #2;
  endtask : tick

  // Waits until every noted result has shown up, then keeps chip select high long enough.
  task automatic settle();
    int n;
    n = 0;
    while ((st_q.size() != 0 || go_q.size() != 0 || abort_due != 0) && n < 300) begin
      tick(1);
      n++;
    end
    if (st_q.size() != 0 || go_q.size() != 0 || abort_due != 0) begin
      num_errors++;
      $display("BAD t=%0t pending=%h exp=%h", $time, st_q.size() + go_q.size(), 0);
      test_done();
    end
    tick(6);
  endtask : settle

  task automatic frame(input logic [7:0] op, input logic [23:0] addr, input int nbits);
    lfsr_state = lfsr_next(lfsr_state);
    read_addr = lfsr_state[31:8];
    // Protection only matters to page writes, so those keep what the scenario has set.
    if (!(op inside {PAGE_WRITE_CMD, QUAD_PAGE_WRITE_CMD})) begin
      {protect_scheme_select, protect_complement, protect_range_bits} = lfsr_state[14:8];
    end
    flash_host_model_i.send(op, addr, nbits, lfsr_state[2:0]);
    settle();
  endtask : frame

  task automatic start_op(input op_kind_e k, input logic [23:0] a);
    st_q.push_back(16'h0001);
    engine.kind = k;
    engine.addr = a;
    engine.op_start = 1'b1;
    tick(1);
    engine.op_start = 1'b0;
    settle();
  endtask : start_op

  task automatic done_pulse(input logic [15:0] exp);
    st_q.push_back(exp);
    engine.done = 1'b1;
    tick(1);
    engine.done = 1'b0;
    settle();
  endtask : done_pulse

  task automatic read_chk(input logic [23:0] a, input logic exp);
    read_addr = a;
    tick(2);
    chk_level(read_blocked, exp);
  endtask : read_chk

  // Every status change and every pulse is matched against the oldest note.
  always @(negedge clock) begin
    if (reset_n === 1'b1) begin
      if (status_word !== prev_status) begin
        if (st_q.size() == 0) chk_status(status_word, prev_status);
        else chk_status(status_word, st_q.pop_front());
        prev_status = status_word;
      end
      if (nested_program.go === 1'b1) begin
        if (go_q.size() == 0) chk_level(1'b1, 1'b0);
        else chk_addr(nested_program.addr, go_q.pop_front());
      end
      if (op_abort === 1'b1) begin
        chk_level(abort_due != 0, 1'b1);
        abort_due = 0;
      end
    end
  end

  initial begin
    logic [23:0] pa, sa, other, spare;
    reset_n = 1'b0;
    engine = '0;
    read_addr = '0;
    protect_scheme_select = 1'b0;
    protect_complement = 1'b0;
    protect_range_bits = 5'h00;
    tick(12);
    reset_n = 1'b1;
    tick(2);
    chk_status(status_word, STATUS_RESET);
    chk_level(array_halt | op_abort | nested_program.go, 1'b0);
    lfsr_state = lfsr_next(lfsr_state);
    pa = {5'h00, lfsr_state[18:8], 8'h00};
    sa = {5'h00, lfsr_state[18:12], 12'h000};
    other = sa ^ 24'h010000;
    spare = sa ^ 24'h020000;
    frame(SUSPEND_CMD, 24'h000000, 8);
    chk_level(array_halt, 1'b0);
    start_op(KIND_PAGE_PROG, pa);
    st_q.push_back(16'h8000);
    frame(SUSPEND_CMD, 24'h000000, 8);
    chk_level(array_halt, 1'b1);
    read_chk(pa + 24'h000010, 1'b1);
    read_chk(pa ^ 24'h000100, 1'b0);
    foreach (SUSPEND_OPS[i]) if (SUSPEND_OPS[i] != RESUME_CMD) frame(SUSPEND_OPS[i], 24'h000000, 8);
    foreach (ERASE_SUSPEND_OPS[i]) frame(ERASE_SUSPEND_OPS[i], other, 32);
    foreach (ANYTIME_OPS[i]) if (ANYTIME_OPS[i] != RESET_FIRE_CMD) frame(ANYTIME_OPS[i], 24'h000000, 8);
    st_q.push_back(16'h0003);
    frame(RESUME_CMD, 24'h000000, 8);
    chk_level(array_halt, 1'b0);
    tick(RESUME_HOLD);
    st_q.push_back(16'h8000);
    frame(SUSPEND_CMD, 24'h000000, 8);
    st_q.push_back(16'h0003);
    frame(RESUME_CMD, 24'h000000, 8);
    done_pulse(16'h0000);
    frame(RESUME_CMD, 24'h000000, 8);
    $display("test program suspend done");
    start_op(KIND_SECTOR_ERASE, sa);
    st_q.push_back(16'h8000);
    frame(SUSPEND_CMD, 24'h000000, 8);
    read_chk(sa + 24'h000FFF, 1'b1);
    read_chk(sa ^ 24'h001000, 1'b0);
    st_q.push_back(16'h8002);
    frame(WRITE_ENABLE_CMD, 24'h000000, 8);
    st_q.push_back(16'h8003);
    go_q.push_back(other);
    {protect_scheme_select, protect_complement, protect_range_bits} = 7'h00;
    frame(PAGE_WRITE_CMD, other, 32);
    frame(SUSPEND_CMD, 24'h000000, 8);
    chk_level(array_halt, 1'b1);
    done_pulse(16'h8000);
    st_q.push_back(16'h8002);
    frame(WRITE_ENABLE_CMD, 24'h000000, 8);
    frame(QUAD_PAGE_WRITE_CMD, sa + 24'h000100, 32);
    frame(SINGLE_LOCK_CMD, other, 32);
    protect_scheme_select = 1'b1;
    frame(PAGE_WRITE_CMD, other, 32);
    {protect_scheme_select, protect_complement, protect_range_bits} = 7'h20;
    frame(PAGE_WRITE_CMD, other, 32);
    protect_complement = 1'b0;
    st_q.push_back(16'h8000);
    frame(WRITE_DISABLE_CMD, 24'h000000, 8);
    st_q.push_back(16'h0003);
    frame(RESUME_CMD, 24'h000000, 8);
    done_pulse(16'h0000);
    $display("test erase suspend done");
    frame(RESET_ARM_CMD, 24'h000000, 8);
    frame(IDLE_CMD, 24'h000000, 8);
    frame(RESET_FIRE_CMD, 24'h000000, 8);
    frame(RESET_ARM_CMD, 24'h000000, 8);
    abort_due = 1;
    frame(RESET_FIRE_CMD, 24'h000000, 8);
    $display("test reset arm done");
    st_q.push_back(16'h0002);
    frame(WRITE_ENABLE_CMD, 24'h000000, 8);
    st_q.push_back(16'h0000);
    frame(SINGLE_UNLOCK_CMD, other, 32);
    st_q.push_back(16'h0002);
    frame(WRITE_ENABLE_CMD, 24'h000000, 8);
    st_q.push_back(16'h0000);
    frame(SINGLE_UNLOCK_CMD, spare, 32);
    st_q.push_back(16'h0002);
    frame(WRITE_ENABLE_CMD, 24'h000000, 8);
    st_q.push_back(16'h0000);
    frame(SINGLE_LOCK_CMD, other, 32);
    st_q.push_back(16'h0002);
    frame(WRITE_ENABLE_CMD, 24'h000000, 8);
    frame(SINGLE_LOCK_CMD, spare, 31);
    frame(SINGLE_LOCK_CMD, spare, 25);
    st_q.push_back(16'h0000);
    frame(WRITE_DISABLE_CMD, 24'h000000, 8);
    // Lock bits only show through a page write inside an erase suspend.
    start_op(KIND_BLOCK64_ERASE, sa);
    st_q.push_back(16'h8000);
    frame(SUSPEND_CMD, 24'h000000, 8);
    read_chk({sa[23:16], 16'hFFFF}, 1'b1);
    st_q.push_back(16'h8002);
    frame(WRITE_ENABLE_CMD, 24'h000000, 8);
    protect_scheme_select = 1'b1;
    frame(PAGE_WRITE_CMD, other, 32);
    st_q.push_back(16'h8003);
    go_q.push_back(spare);
    frame(PAGE_WRITE_CMD, spare, 32);
    done_pulse(16'h8000);
    $display("test single lock done");
    test_done();
  end
endmodule : flash_suspend_resume_lock_tb_top
